// file: hdl/tag_data_write_lock_handler.sv
/*
  Data-transfer command handler of a passive tag: status port read,
  byte and masked four-byte writes, broadcast writes, lock and lock
  query. Assumes a decoded, CRC-checked command frame arrives as one
  pulse and that an outside coder frames and CRCs each reply.
*/
`timescale 1ns/1ps

// What this block does
// - Serial-matched port read enters session, returns addressed 8-bit port.
// - Port 0: bit1 program-success, bit0 session hold; rest read zero.
// - Directed commands failing match or state conditions get no reply.
// - Serial write enters session; locked byte errors, else ack then program.
// - Each write or lock passing its match and state checks sets or clears program-success flag.
// - Serial write or lock query marks its byte lock-eligible.
// - Masked write enters session; any locked of four gives error.
// - Mask bits B7..B4 enable bytes at address plus 0..3.
// - Masked write never leaves its bytes lock-eligible.
// - Lock in session with eligible valid byte: ack then program lock.
// - Lock with bad address or ineligible byte: ack-fail, no program.
// - Query enters session; unlocked byte gives ack-pass or ack-fail.
// - Query on locked byte gives locked-pass or locked-fail by flag.
// - Broadcast write in arbitration/session programs unlocked byte; silent.
// - Broadcast masked write programs selected unlocked bytes, silent.
// - Reply goes out before programming; reader waits after its CRC.
// - Port read reply is preamble, one data byte, then CRC.
// - Fast-rate replies carry their meaning in fixed check words.
module tag_data_write_lock_handler
  import tag_cmd_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                cmd_valid,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [SERIAL_W-1:0] cmd_serial,
  input  wire logic [ADDR_W-1:0]   cmd_addr,
  input  wire logic [7:0]          cmd_mask,
  input  wire logic [31:0]         cmd_data,
  input  wire logic                cmd_crc_ok,
  input  wire logic                cmd_fast_rate,
  input  wire logic [SERIAL_W-1:0] tag_serial_number,
  input  wire logic                enter_arbitration,
  input  wire logic                enter_ready,
  input  wire logic                supply_ok,
  input  wire logic [ADDR_W-1:0]   mem_rd_addr,
  output logic                     reply_valid_q,
  output logic      [7:0]          reply_byte_q,
  output logic      [15:0]         reply_fast_crc_q,
  output logic                     reply_fast_q,
  output logic                     busy_q,
  output logic                     session_hold_flag_q,
  output logic                     write_ok_q,
  output tag_state_type            tag_state_q,
  output logic      [7:0]          mem_rd_data
);

  typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_PROG} fsm_type;

  fsm_type             fsm_q, fsm_d;
  logic                prog_start_q;
  logic                prog_lock_q;
  logic [ADDR_W-1:0]   prog_addr_q;
  logic [3:0]          prog_en_q;
  logic [31:0]         prog_data_q;
  logic [3:0]          look_lock;
  logic                prog_done;
  logic                prog_ok;
  logic                elig_valid;
  logic [ADDR_W-1:0]   elig_addr;

  // ==========================================================
  // acceptance and match
  wire good = cmd_valid && (fsm_q == ST_IDLE) && cmd_crc_ok;
  wire hit  = (cmd_serial == tag_serial_number);
  wire dir  = good && hit;
  wire in_sess = (tag_state_q == TAG_SESSION);
  wire arb_or_sess = in_sess || (tag_state_q == TAG_ARBITRATION);

  wire [ADDR_W-1:0] page = {cmd_addr[ADDR_W-1:2], 2'b00};
  wire addr_ok   = (cmd_addr < ADDR_W'(MEM_DEPTH));
  wire byte_lock = look_lock[cmd_addr[1:0]];
  wire any_lock  = |look_lock;
  wire elig_hit  = elig_valid && (elig_addr == cmd_addr);

  // ==========================================================
  // command classification
  wire do_rport = dir && (cmd_code == CMD_READ_PORT);
  wire do_write = dir && (cmd_code == CMD_WRITE);
  wire do_quad  = dir && (cmd_code == CMD_QUAD);
  wire do_lock  = dir && (cmd_code == CMD_LOCK) && in_sess;
  wire do_query = dir && (cmd_code == CMD_QUERY);
  wire do_bw    = good && (cmd_code == CMD_BCAST) && arb_or_sess;
  wire do_bq    = good && (cmd_code == CMD_BCAST_QUAD) && arb_or_sess;

  wire enter_sess = do_rport | do_write | do_quad | do_query;
  wire reply_now  = enter_sess | do_lock;
  wire flag_touch = do_write | do_quad | do_lock | do_bw | do_bq;

  // ==========================================================
  // byte enables: mask bit B(7-i) selects byte address+i
  logic [3:0] mask_en;
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign mask_en[i] = cmd_mask[MASK_TOP - i];
  end
  wire [3:0] single_en = 4'(4'h1 << cmd_addr[1:0]);

  // which bytes get programmed, per command
  wire [3:0] wr_en =
      do_write ? (single_en & ~look_lock)
    : do_quad  ? (any_lock ? 4'h0 : mask_en)
    : do_bw    ? (single_en & ~look_lock)
    : do_bq    ? (mask_en & ~look_lock)
    : 4'h0;
  wire lock_go = do_lock && addr_ok && elig_hit;
  wire prog_go = (|wr_en) || lock_go;

  // single-byte data sits in the low lane; replicate to every lane
  wire [31:0] wr_data = (do_quad || do_bq) ? cmd_data
                        : {4{cmd_data[7:0]}};

  // ==========================================================
  // status port and reply selection
  wire [7:0] tag_status_port = {6'h00, write_ok_q, session_hold_flag_q};
  wire [7:0] port_val = (cmd_addr == PORT_STATUS) ? tag_status_port
                        : PORT_RSVD_VAL;
  wire [7:0] query_code =
      byte_lock ? (write_ok_q ? RPL_LOCKED_PASS : RPL_LOCKED_FAIL)
                : (write_ok_q ? RPL_ACK_PASS : RPL_ACK_FAIL);
  wire [7:0] reply_code =
      do_rport ? port_val
    : do_write ? (byte_lock ? RPL_ERROR : RPL_ACK)
    : do_quad  ? (any_lock ? RPL_ERROR : RPL_ACK)
    : do_lock  ? (lock_go ? RPL_ACK : RPL_ACK_FAIL)
    : query_code;

  // fast-rate check word for the chosen reply
  logic [15:0] fast_crc;
  always_comb begin
    fast_crc = FCRC_ACK;
    if (do_rport) begin
      if (cmd_addr != PORT_STATUS)
        fast_crc = FCRC_ACK;
      else case ({write_ok_q, session_hold_flag_q})
        2'b00:   fast_crc = FCRC_PORT_00;
        2'b01:   fast_crc = FCRC_PORT_01;
        2'b10:   fast_crc = FCRC_PORT_10;
        default: fast_crc = FCRC_PORT_11;
      endcase
    end else begin
      case (reply_code)
        RPL_ACK_PASS:    fast_crc = FCRC_ACK_PASS;
        RPL_ERROR:       fast_crc = FCRC_ERROR;
        RPL_LOCKED_FAIL: fast_crc = FCRC_ERROR;
        RPL_LOCKED_PASS: fast_crc = FCRC_LOCKED_PASS;
        default:         fast_crc = FCRC_ACK;
      endcase
    end
  end

  // ==========================================================
  // sequencer: reply cycle, then program start, then wait for done
  always_comb begin
    case (fsm_q)
      ST_IDLE:   fsm_d = (good && prog_go) ? ST_LAUNCH : ST_IDLE;
      ST_LAUNCH: fsm_d = ST_PROG;
      ST_PROG:   fsm_d = prog_done ? ST_IDLE : ST_PROG;
      default:   fsm_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fsm_q        <= ST_IDLE;
      busy_q       <= 1'b0;
      prog_start_q <= 1'b0;
    end else begin
      fsm_q        <= fsm_d;
      busy_q       <= (fsm_d != ST_IDLE);
      prog_start_q <= (fsm_q == ST_LAUNCH);
    end
  end

  // program request, captured when the command is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_lock_q <= 1'b0;
      prog_addr_q <= '0;
      prog_en_q   <= 4'h0;
      prog_data_q <= 32'h0000_0000;
    end else if (good && prog_go) begin
      prog_lock_q <= lock_go;
      prog_addr_q <= lock_go ? cmd_addr : page;
      prog_en_q   <= wr_en;
      prog_data_q <= wr_data;
    end
  end

  // ==========================================================
  // reply outputs: one pulse in the cycle after the command
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reply_valid_q    <= 1'b0;
      reply_byte_q     <= 8'h00;
      reply_fast_crc_q <= 16'h0000;
      reply_fast_q     <= 1'b0;
    end else begin
      reply_valid_q <= reply_now;
      if (reply_now) begin
        reply_byte_q     <= reply_code;
        reply_fast_crc_q <= fast_crc;
        reply_fast_q     <= cmd_fast_rate;
      end
    end
  end

  // ==========================================================
  // tag state and session hold; the taken command wins over the
  // identification side, which cannot act in the same frame anyway
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tag_state_q         <= TAG_READY;
      session_hold_flag_q <= 1'b0;
    end else if (enter_sess) begin
      tag_state_q         <= TAG_SESSION;
      session_hold_flag_q <= 1'b1;
    end else if (enter_ready) begin
      tag_state_q         <= TAG_READY;
      session_hold_flag_q <= 1'b0;
    end else if (enter_arbitration) begin
      tag_state_q         <= TAG_ARBITRATION;
    end
  end

  // program-success flag: result of the cycle, or cleared when none ran
  always_ff @(posedge sys_clk) begin
    if (rst)
      write_ok_q <= 1'b0;
    else if (fsm_q == ST_PROG && prog_done)
      write_ok_q <= prog_ok;
    else if (flag_touch && !prog_go)
      write_ok_q <= 1'b0;
  end

  // ==========================================================
  // submodules
  lock_eligible_tracker u_elig (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .mark       (do_write | do_query),
    .clear      (do_quad | lock_go),
    .mark_addr  (cmd_addr),
    .elig_valid (elig_valid),
    .elig_addr  (elig_addr)
  );

  nvm_byte_store #(.PROG_CYCLES(PROG_CYCLES)) u_nvm (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .prog_start (prog_start_q),
    .prog_lock  (prog_lock_q),
    .prog_addr  (prog_addr_q),
    .prog_en    (prog_en_q),
    .prog_data  (prog_data_q),
    .supply_ok  (supply_ok),
    .look_addr  (page),
    .look_lock  (look_lock),
    .rd_addr    (mem_rd_addr),
    .rd_data    (mem_rd_data),
    .prog_done  (prog_done),
    .prog_ok    (prog_ok)
  );

  // ==========================================================
  // checks
  a_crc_discard: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_valid && !cmd_crc_ok && fsm_q == ST_IDLE) |=>
      !reply_valid_q && fsm_q == ST_IDLE)
    else $error("bad-CRC command had an effect");

  a_port_read: assert property (@(posedge sys_clk) disable iff (rst)
    do_rport |=> reply_valid_q && reply_byte_q == $past(port_val)
      && tag_state_q == TAG_SESSION)
    else $error("port read reply wrong");

  a_sess_enter: assert property (@(posedge sys_clk) disable iff (rst)
    enter_sess |=> tag_state_q == TAG_SESSION && session_hold_flag_q)
    else $error("matched command left session off");

  a_port_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
    do_rport |=> reply_byte_q[7:2] == 6'h00)
    else $error("reserved port bits not zero");

  a_silent_miss: assert property (@(posedge sys_clk) disable iff (rst)
    (good && !hit) |=> !reply_valid_q)
    else $error("reply to a foreign serial");

  a_lock_no_sess: assert property (@(posedge sys_clk) disable iff (rst)
    (dir && cmd_code == CMD_LOCK && !in_sess) |=> !reply_valid_q && !busy_q)
    else $error("lock outside session answered");

  a_mark_elig: assert property (@(posedge sys_clk) disable iff (rst)
    (do_write || do_query) |=> elig_valid && elig_addr == $past(cmd_addr))
    else $error("byte not marked lock-eligible");

  a_quad_unmark: assert property (@(posedge sys_clk) disable iff (rst)
    do_quad |=> !elig_valid)
    else $error("masked write left a byte eligible");

  a_query_pass: assert property (@(posedge sys_clk) disable iff (rst)
    (do_query && !byte_lock && write_ok_q) |=> reply_byte_q == RPL_ACK_PASS)
    else $error("query reply not ack-pass");

  a_query_lfail: assert property (@(posedge sys_clk) disable iff (rst)
    (do_query && byte_lock && !write_ok_q) |=> reply_byte_q == RPL_LOCKED_FAIL)
    else $error("query reply not locked-fail");

  a_ack_first: assert property (@(posedge sys_clk) disable iff (rst)
    (do_write && !byte_lock) |=> reply_valid_q && reply_byte_q == RPL_ACK
      ##1 prog_start_q)
    else $error("ack did not precede programming");

  a_locked_err: assert property (@(posedge sys_clk) disable iff (rst)
    (do_quad && any_lock) |=> reply_byte_q == RPL_ERROR && !busy_q
      ##1 !prog_start_q)
    else $error("locked masked write not refused");

  a_flag_result: assert property (@(posedge sys_clk) disable iff (rst)
    (fsm_q == ST_PROG && prog_done) |=> write_ok_q == $past(prog_ok))
    else $error("program flag not updated");

  a_bcast_silent: assert property (@(posedge sys_clk)
    disable iff (rst) (do_bw || do_bq) |=> !reply_valid_q)
    else $error("broadcast write replied");

  a_bq_lanes: assert property (@(posedge sys_clk) disable iff (rst)
    (do_bq && prog_go) |=> (prog_en_q & ~($past(mask_en) & ~$past(look_lock)))
      == 4'h0)
    else $error("broadcast masked write hit a wrong byte");

  a_lock_fail: assert property (@(posedge sys_clk) disable iff (rst)
    (do_lock && !elig_hit) |=> reply_byte_q == RPL_ACK_FAIL ##1
      !prog_start_q)
    else $error("ineligible lock not refused");

endmodule : tag_data_write_lock_handler

// file: pkg/tag_cmd_pkg.sv
/*
  Shared constants for the tag data-transfer command handler: command
  codes, reply codes, port layout, fixed fast-rate check words, memory
  size and programming time. Assumes a 25 MHz tag clock.
*/
package tag_cmd_pkg;

  // ==========================================================
  // geometry
  localparam int SERIAL_W  = 64;
  localparam int ADDR_W    = 8;
  localparam int MEM_DEPTH = 224;            // bytes 00..DF usable
  localparam int MASK_TOP  = 7;              // B7 selects address+0

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PROG_TIME_NS    = 13300000;  // 13.3 ms, least
  localparam int PROG_CYCLES_DEF =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_READ_PORT   = 8'h0C;
  localparam logic [7:0] CMD_WRITE       = 8'h0D;
  localparam logic [7:0] CMD_QUAD        = 8'h1B;
  localparam logic [7:0] CMD_LOCK        = 8'h0F;
  localparam logic [7:0] CMD_QUERY       = 8'h11;
  localparam logic [7:0] CMD_BCAST       = 8'h19;
  localparam logic [7:0] CMD_BCAST_QUAD  = 8'h1C;

  // ==========================================================
  // reply codes (data byte in normal-rate replies)
  localparam logic [7:0] RPL_ACK         = 8'h00;
  localparam logic [7:0] RPL_ACK_FAIL    = 8'h01;
  localparam logic [7:0] RPL_ACK_PASS    = 8'h02;
  localparam logic [7:0] RPL_ERROR       = 8'hFF;
  localparam logic [7:0] RPL_LOCKED_FAIL = 8'hFE;
  localparam logic [7:0] RPL_LOCKED_PASS = 8'hFD;

  // fixed check words standing for the reply in fast-rate mode
  localparam logic [15:0] FCRC_ACK         = 16'h1E0F;
  localparam logic [15:0] FCRC_ACK_PASS    = 16'h0E2E;
  localparam logic [15:0] FCRC_ERROR       = 16'h00FF;
  localparam logic [15:0] FCRC_LOCKED_PASS = 16'h10DE;
  // status port in fast-rate mode, by {program ok, session hold}
  localparam logic [15:0] FCRC_PORT_00     = 16'h1E0F;
  localparam logic [15:0] FCRC_PORT_01     = 16'h0E2E;
  localparam logic [15:0] FCRC_PORT_10     = 16'h3E4D;
  localparam logic [15:0] FCRC_PORT_11     = 16'h2E6C;

  // ==========================================================
  // status port
  localparam logic [7:0] PORT_STATUS   = 8'h00;
  localparam int         HOLD_BIT      = 0;
  localparam int         WOK_BIT       = 1;
  localparam logic [7:0] PORT_RSVD_VAL = 8'h00;

  typedef enum logic [1:0] {
    TAG_READY,
    TAG_ARBITRATION,
    TAG_SESSION
  } tag_state_type;

endpackage : tag_cmd_pkg

// file: hdl/lock_eligible_tracker.sv
/*
  Remembers the one byte address that a following lock command may
  protect. Assumes marks and clears arrive as one-cycle pulses.
*/
`timescale 1ns/1ps
module lock_eligible_tracker
  import tag_cmd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              mark,
  input  wire logic              clear,
  input  wire logic [ADDR_W-1:0] mark_addr,
  output logic                   elig_valid,
  output logic      [ADDR_W-1:0] elig_addr
);

  // ==========================================================
  // eligibility register; a mark beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      elig_valid <= 1'b0;
      elig_addr  <= '0;
    end else if (mark) begin
      elig_valid <= 1'b1;
      elig_addr  <= mark_addr;
    end else if (clear) begin
      elig_valid <= 1'b0;
    end
  end

endmodule : lock_eligible_tracker

// file: hdl/nvm_byte_store.sv
/*
  Nonvolatile byte store with per-byte lock bits and a timed program
  cycle. Assumes start is a pulse given only while idle.
*/
`timescale 1ns/1ps
module nvm_byte_store
  import tag_cmd_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              prog_start,
  input  wire logic              prog_lock,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [3:0]        prog_en,
  input  wire logic [31:0]       prog_data,
  input  wire logic              supply_ok,
  input  wire logic [ADDR_W-1:0] look_addr,
  output logic      [3:0]        look_lock,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data,
  output logic                   prog_done,
  output logic                   prog_ok
);

  localparam int CW = $clog2(PROG_CYCLES + 1);

  logic [7:0]    data_mem [MEM_DEPTH];
  logic          lock_mem [MEM_DEPTH];
  logic          run_q;
  logic          good_q;
  logic [CW-1:0] cnt_q;
  wire           last = run_q && (cnt_q == CW'(PROG_CYCLES - 1));

  // ==========================================================
  // lock lookup per lane; bytes beyond the array count as locked
  for (genvar i = 0; i < 4; i++) begin : g_look
    wire [ADDR_W:0] a = {1'b0, look_addr} + (ADDR_W+1)'(i);
    assign look_lock[i] = (a >= (ADDR_W+1)'(MEM_DEPTH)) ? 1'b1
                          : lock_mem[a[ADDR_W-1:0]];
  end

  // ==========================================================
  // program timer; a supply dip anywhere spoils the cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q     <= 1'b0;
      good_q    <= 1'b0;
      cnt_q     <= '0;
      prog_done <= 1'b0;
      prog_ok   <= 1'b0;
    end else begin
      prog_done <= last;
      if (prog_start) begin
        run_q  <= 1'b1;
        good_q <= supply_ok;
        cnt_q  <= '0;
      end else if (run_q) begin
        good_q <= good_q & supply_ok;
        cnt_q  <= cnt_q + CW'(1);
        if (last) begin
          run_q   <= 1'b0;
          prog_ok <= good_q & supply_ok;
        end
      end
    end
  end

  // ==========================================================
  // commit only at the end, so an aborted cycle changes nothing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int j = 0; j < MEM_DEPTH; j++) lock_mem[j] <= 1'b0;
    end else if (last && good_q && supply_ok) begin
      if (prog_lock) begin
        lock_mem[prog_addr] <= 1'b1;
      end else begin
        for (int j = 0; j < 4; j++) begin
          if (prog_en[j]) data_mem[prog_addr + ADDR_W'(j)] <=
              prog_data[8*j +: 8];
        end
      end
    end
  end

  // registered read port for the rest of the tag
  always_ff @(posedge sys_clk) begin
    if (rst) rd_data <= 8'h00;
    else     rd_data <= (rd_addr < ADDR_W'(MEM_DEPTH)) ?
                        data_mem[rd_addr] : 8'h00;
  end

  initial begin
    if (PROG_CYCLES < 1) $error("PROG_CYCLES must be at least 1");
  end

endmodule : nvm_byte_store

// file: test/reader_model.sv
/*
  Interrogator model: issues decoded command frames on the handler's
  command port. Assumes the bench owns sys_clk; drives at falling edges.
*/
`timescale 1ns/1ps
module reader_model
  import tag_cmd_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                busy_q,
  output logic                     cmd_valid,
  output logic      [7:0]          cmd_code,
  output logic      [SERIAL_W-1:0] cmd_serial,
  output logic      [ADDR_W-1:0]   cmd_addr,
  output logic      [7:0]          cmd_mask,
  output logic      [31:0]         cmd_data,
  output logic                     cmd_crc_ok,
  output logic                     cmd_fast_rate
);
  // ==========================================================
  // frame driver
  initial begin
    {cmd_valid, cmd_code, cmd_serial, cmd_addr} = '0;
    {cmd_mask, cmd_data, cmd_crc_ok, cmd_fast_rate} = '0;
  end

  // one frame, one cycle long
  task automatic issue(input logic [7:0] c, input logic [63:0] s,
    input logic [7:0] a, input logic [7:0] m, input logic [31:0] d,
    input logic ok, input logic f);
    logic quad;
    logic bcast;
    quad = (c == CMD_QUAD) || (c == CMD_BCAST_QUAD);
    bcast = (c == CMD_BCAST) || (c == CMD_BCAST_QUAD);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_serial = s;
    cmd_addr = quad ? {a[7:2], 2'b00} : a;
    cmd_mask = m;
    cmd_data = d;
    cmd_crc_ok = ok;
    cmd_fast_rate = bcast ? 1'b0 : f;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // released fields flip so a stale frame is never read as fresh
    {cmd_code, cmd_addr, cmd_mask} = ~{cmd_code, cmd_addr, cmd_mask};
    cmd_data = ~cmd_data;
  endtask : issue

  // quiet time after the frame while the tag programs
  task automatic wait_idle();
    repeat (40) if (busy_q) @(negedge sys_clk);
  endtask : wait_idle
endmodule : reader_model

// file: test/test_tag_data_write_lock_handler.sv
/*
  Self-checking bench for the tag command handler, driven through the
  interrogator model. Assumes program time shortened to 8 cycles.
*/
`timescale 1ns/1ps
module test_tag_data_write_lock_handler
  import tag_cmd_pkg::*;
;
  localparam logic [63:0] SER = 64'h0123_4567_89AB_CDEF;
  logic sys_clk = 1'b0, rst = 1'b1, supply_ok = 1'b1;
  logic enter_arbitration = 1'b0, enter_ready = 1'b0;
  logic [7:0] mem_rd_addr = 8'h00;
  int fails = 0, cmp_count = 0;
  wire logic cmd_valid, cmd_crc_ok, cmd_fast_rate, reply_valid_q;
  wire logic reply_fast_q, busy_q, session_hold_flag_q, write_ok_q;
  wire logic [7:0] cmd_code, cmd_addr, cmd_mask, reply_byte_q, mem_rd_data;
  wire logic [63:0] cmd_serial;
  wire logic [31:0] cmd_data;
  wire logic [15:0] reply_fast_crc_q;
  wire tag_state_type tag_state_q;

  always #20 sys_clk = ~sys_clk;

  reader_model rdr (.sys_clk(sys_clk), .busy_q(busy_q),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_serial(cmd_serial),
    .cmd_addr(cmd_addr), .cmd_mask(cmd_mask), .cmd_data(cmd_data),
    .cmd_crc_ok(cmd_crc_ok), .cmd_fast_rate(cmd_fast_rate));

  tag_data_write_lock_handler #(.PROG_CYCLES(8)) dut (.sys_clk(sys_clk),
    .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_serial(cmd_serial), .cmd_addr(cmd_addr), .cmd_mask(cmd_mask),
    .cmd_data(cmd_data), .cmd_crc_ok(cmd_crc_ok),
    .cmd_fast_rate(cmd_fast_rate), .tag_serial_number(SER),
    .enter_arbitration(enter_arbitration), .enter_ready(enter_ready),
    .supply_ok(supply_ok), .mem_rd_addr(mem_rd_addr),
    .reply_valid_q(reply_valid_q), .reply_byte_q(reply_byte_q),
    .reply_fast_crc_q(reply_fast_crc_q), .reply_fast_q(reply_fast_q),
    .busy_q(busy_q), .session_hold_flag_q(session_hold_flag_q),
    .write_ok_q(write_ok_q), .tag_state_q(tag_state_q),
    .mem_rd_data(mem_rd_data));

  // ==========================================================
  // compare and access tasks
  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // reply stands one cycle only; issue returns inside that very cycle
  task automatic expect_reply(input logic [8:0] exp);
    check("reply_valid_q", {31'd0, exp[8]}, {31'd0, reply_valid_q});
    if (exp[8]) check("reply_byte_q", {24'd0, exp[7:0]},
      {24'd0, reply_byte_q});
  endtask : expect_reply

  task automatic run(input logic [7:0] c, a, m, input logic [31:0] d,
    input logic [8:0] exp);
    rdr.issue(c, SER, a, m, d, 1'b1, 1'b0);
    expect_reply(exp);
    rdr.wait_idle();
    check("busy_q", 32'd0, {31'd0, busy_q});
  endtask : run

  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    mem_rd_addr = a;
    @(negedge sys_clk);
    check("mem_rd_data", {24'd0, exp}, {24'd0, mem_rd_data});
  endtask : peek

  task automatic flag(input logic exp);
    check("write_ok_q", {31'd0, exp}, {31'd0, write_ok_q});
  endtask : flag

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // ==========================================================
  // tests; the watchdog allows far more than the ~190 cycles needed
  initial begin
    #800000;
    fails++;
    summarize();
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    rdr.issue(CMD_READ_PORT, ~SER, 8'h00, 8'h00, 0, 1'b1, 1'b0);
    expect_reply(9'h000);
    rdr.issue(CMD_READ_PORT, SER, 8'h00, 8'h00, 0, 1'b1, 1'b0);
    expect_reply(9'h100);
    check("tag_state_q", 32'(TAG_SESSION), 32'(tag_state_q));
    run(CMD_READ_PORT, 8'h00, 0, 0, 9'h101);
    run(CMD_READ_PORT, 8'h01, 0, 0, 9'h100);
    $display("test port read done");
    run(CMD_WRITE, 8'h10, 0, 32'hA5, {1'b1, RPL_ACK});
    flag(1'b1);
    peek(8'h10, 8'hA5);
    run(CMD_QUERY, 8'h10, 0, 0, {1'b1, RPL_ACK_PASS});
    run(CMD_LOCK, 8'h10, 0, 0, {1'b1, RPL_ACK});
    flag(1'b1);
    run(CMD_QUERY, 8'h10, 0, 0, {1'b1, RPL_LOCKED_PASS});
    run(CMD_WRITE, 8'h10, 0, 32'h5A, {1'b1, RPL_ERROR});
    flag(1'b0);
    peek(8'h10, 8'hA5);
    run(CMD_QUERY, 8'h10, 0, 0, {1'b1, RPL_LOCKED_FAIL});
    run(CMD_LOCK, 8'h20, 0, 0, {1'b1, RPL_ACK_FAIL});
    run(CMD_LOCK, 8'hE0, 0, 0, {1'b1, RPL_ACK_FAIL});
    $display("test write and lock done");
    run(CMD_QUERY, 8'h20, 0, 0, {1'b1, RPL_ACK_FAIL});
    run(CMD_QUAD, 8'h20, 8'hF0, 32'h44332211, {1'b1, RPL_ACK});
    run(CMD_QUAD, 8'h20, 8'hA0, 32'hDDCCBBAA, {1'b1, RPL_ACK});
    flag(1'b1);
    peek(8'h20, 8'hAA);
    peek(8'h21, 8'h22);
    peek(8'h22, 8'hCC);
    peek(8'h23, 8'h44);
    run(CMD_LOCK, 8'h20, 0, 0, {1'b1, RPL_ACK_FAIL});
    run(CMD_QUAD, 8'h10, 8'h10, 32'h0, {1'b1, RPL_ERROR});
    $display("test masked write done");
    run(CMD_BCAST, 8'h30, 0, 32'h5A, 9'h000);
    flag(1'b1);
    peek(8'h30, 8'h5A);
    run(CMD_BCAST, 8'h10, 0, 32'h00, 9'h000);
    peek(8'h10, 8'hA5);
    run(CMD_BCAST_QUAD, 8'h10, 8'hF0, 32'h04030201, 9'h000);
    peek(8'h10, 8'hA5);
    peek(8'h12, 8'h03);
    $display("test broadcast done");
    enter_ready = 1'b1;
    @(negedge sys_clk);
    enter_ready = 1'b0;
    check("session_hold_flag_q", 32'd0, {31'd0, session_hold_flag_q});
    run(CMD_BCAST, 8'h30, 0, 32'h11, 9'h000);
    peek(8'h30, 8'h5A);
    run(CMD_LOCK, 8'h30, 0, 0, 9'h000);
    enter_arbitration = 1'b1;
    @(negedge sys_clk);
    enter_arbitration = 1'b0;
    run(CMD_BCAST, 8'h34, 0, 32'h3C, 9'h000);
    peek(8'h34, 8'h3C);
    supply_ok = 1'b0;
    run(CMD_WRITE, 8'h35, 0, 32'h99, {1'b1, RPL_ACK});
    supply_ok = 1'b1;
    flag(1'b0);
    $display("test state and supply done");
    rdr.issue(CMD_WRITE, SER, 8'h30, 0, 32'h77, 1'b0, 1'b0);
    expect_reply(9'h000);
    peek(8'h30, 8'h5A);
    rdr.issue(CMD_WRITE, SER, 8'h31, 0, 32'h66, 1'b1, 1'b1);
    expect_reply({1'b1, RPL_ACK});
    check("reply_fast_q", 32'd1, {31'd0, reply_fast_q});
    check("reply_fast_crc_q", {16'd0, FCRC_ACK},
      {16'd0, reply_fast_crc_q});
    rdr.wait_idle();
    $display("test crc and fast rate done");
    summarize();
  end
endmodule : test_tag_data_write_lock_handler
